// File: rtl/sdc_pkg.sv
// Package for the serial converter input front end: frame layout, modes, timing.
// Assumes a single 25 MHz system clock samples the three-wire link.
package sdc_pkg;

  // Frame geometry
  localparam int unsigned FRAME_BITS   = 16;
  localparam int unsigned CODE_BITS    = 12;
  localparam int unsigned CNT_BITS     = 5;
  localparam int unsigned MODE_HI_POS  = 13;   // frame_bit_13
  localparam int unsigned MODE_LO_POS  = 12;   // frame_bit_12
  localparam int unsigned CODE_MSB_POS = 11;
  localparam int unsigned CODE_LSB_POS = 0;
  localparam logic [4:0]  LAST_EDGE    = 5'h10;

  // Reset values
  localparam logic [11:0] CODE_RST  = 12'h000;
  localparam logic [15:0] SHIFT_RST = 16'h0000;

  // Timing: host minimum sync high time, in ns and in system clocks
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned SYNC_HIGH_MIN_NS = 33;
  localparam int unsigned SYNC_HIGH_CYC =
    (SYNC_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Power modes
  typedef enum logic [1:0] {
    SDC_PM_NORMAL = 2'h0,
    SDC_PM_1K     = 2'h1,
    SDC_PM_100K   = 2'h2,
    SDC_PM_HIZ    = 2'h3
  } sdc_mode_t;

  // Link pins travelling together
  typedef struct packed {
    logic sync_n;
    logic sclk;
    logic din;
  } sdc_link_t;

  // Output termination controls
  typedef struct packed {
    logic amp_on;
    logic term_1k;
    logic term_100k;
  } sdc_out_t;

  // Frame receiver states, one-hot
  typedef enum logic [2:0] {
    SDC_ST_IDLE  = 3'b001,
    SDC_ST_SHIFT = 3'b010,
    SDC_ST_DONE  = 3'b100
  } sdc_state_t;

  // Whole module state
  typedef struct packed {
    logic [1:0]  sync_s1;
    logic [1:0]  sclk_s1;
    logic [1:0]  din_s1;
    logic        sync_prev;
    logic        sclk_prev;
    sdc_state_t  state;
    logic [4:0]  cnt;
    logic [15:0] shift;
    logic [11:0] code;
    sdc_mode_t   mode;
    logic        upd;
  } sdc_state_all_t;

endpackage : sdc_pkg

// File: rtl/sdc_core.sv
// Input control of a 12-bit serial-loaded converter: frame receiver,
// code register and power-mode decode.
// Assumes link pins are asynchronous; link clock well below clk/2 (bench 320 ns).
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE_01: Shift data on sclk falls while sync low
// RULE_02: Sixteenth fall executes the frame function
// RULE_03: Only sync falling edge opens a frame
// RULE_04: Host keeps sync high 33ns between frames
// RULE_05: Host may idle sync low for power
// RULE_06: Top two frame bits are ignored
// RULE_07: Bits 13..12 choose power mode
// RULE_08: Bits 11..0 load the code register
// RULE_09: Early sync rise aborts, clears shifter
// RULE_10: Code register zero after power-up
// RULE_11: Power-down keeps code register contents
// RULE_12: Power-down cuts amplifier, picks termination
// RULE_13: Code is straight unsigned binary
// RULE_14: Host serial clock at most 30MHz
// RULE_15: Host sends frame MSB first
// RULE_16: Byte hosts hold sync over two bytes
// RULE_17: Counter restarts on sync fall, extras ignored
module sdc_core
  import sdc_pkg::*;
(
  // System
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  // Serial link, asynchronous pins
  input  wire logic             sync_n,
  input  wire logic             sclk,
  input  wire logic             din,
  // Converter core controls
  output logic [CODE_BITS-1:0]  code,
  output sdc_mode_t             power_mode,
  output logic                  power_mode_hi,
  output logic                  power_mode_lo,
  output sdc_out_t              out_ctl,
  output logic                  code_update
);

  // Elaboration guards: the fixed slices below only serve this frame layout
  if (FRAME_BITS != 16 || CODE_BITS != 12) begin : g_chk_layout
    $error("sdc_core: frame layout fixed at 16/12 bits");
  end
  // Counter must reach the last edge without wrapping
  if (LAST_EDGE != 5'(FRAME_BITS) || CNT_BITS < $clog2(FRAME_BITS + 1)) begin : g_chk_count
    $error("sdc_core: edge counter cannot reach the last frame bit");
  end
  // Mode pair sits directly above the code field
  if (MODE_HI_POS != MODE_LO_POS + 1 || MODE_LO_POS != CODE_BITS) begin : g_chk_mode
    $error("sdc_core: mode bits must sit just above the code field");
  end
  // Code field spans the low bits of the frame
  if (CODE_MSB_POS != CODE_BITS - 1 || CODE_LSB_POS != 0) begin : g_chk_code
    $error("sdc_core: code field must start at bit zero");
  end

  sdc_state_all_t st_q;      // All registered state
  sdc_state_all_t st_d;      // Next state
  sdc_link_t      pins;      // Second-stage synchronised pins
  logic           sync_fall; // Frame opens
  logic           sync_rise; // Frame closes or aborts
  logic           sclk_fall; // Bit sample point
  logic           shift_zero; // Shifter holds its cleared value

  // Second synchroniser stage only; first stage read by nothing else
  assign pins.sync_n = st_q.sync_s1[1];
  assign pins.sclk   = st_q.sclk_s1[1];
  assign pins.din    = st_q.din_s1[1];

  // Edge detectors on the stable copies
  assign sync_fall = st_q.sync_prev & ~pins.sync_n;
  assign sync_rise = ~st_q.sync_prev & pins.sync_n;
  assign sclk_fall = st_q.sclk_prev & ~pins.sclk;
  assign shift_zero = (st_q.shift == SHIFT_RST);  // Watched by the abort check

  // Next-state logic
  always_comb begin
    st_d         = st_q;
    st_d.upd     = 1'b0;
    st_d.sync_s1 = {st_q.sync_s1[0], sync_n};
    st_d.sclk_s1 = {st_q.sclk_s1[0], sclk};
    st_d.din_s1  = {st_q.din_s1[0], din};
    st_d.sync_prev = pins.sync_n;
    st_d.sclk_prev = pins.sclk;
    unique case (st_q.state)
      SDC_ST_IDLE: begin
        // Only a falling sync starts a frame; low level alone does not
        if (sync_fall) begin                               // [RULE_03]
          st_d.state = SDC_ST_SHIFT;
          st_d.cnt   = '0;                                 // [RULE_17]
          st_d.shift = SHIFT_RST;
        end
      end
      SDC_ST_SHIFT: begin
        if (sync_rise) begin
          // Interrupted frame: drop everything gathered so far
          st_d.state = SDC_ST_IDLE;                        // [RULE_09]
          st_d.shift = SHIFT_RST;
          st_d.cnt   = '0;
        end else if (sclk_fall) begin
          st_d.shift = {st_q.shift[FRAME_BITS-2:0], pins.din}; // [RULE_01]
          st_d.cnt   = st_q.cnt + 5'h01;
          if (st_q.cnt + 5'h01 == LAST_EDGE) begin
            // Execute at once; bits 15..14 never looked at [RULE_06]
            st_d.code  = {st_q.shift[CODE_MSB_POS-1:CODE_LSB_POS], pins.din}; // [RULE_08] [RULE_02]
            st_d.mode  = sdc_mode_t'(st_q.shift[MODE_HI_POS-1:MODE_LO_POS-1]); // [RULE_07]
            st_d.upd   = 1'b1;
            st_d.state = SDC_ST_DONE;
          end
        end
      end
      SDC_ST_DONE: begin
        // Further clocks ignored until sync goes high then low again
        if (sync_rise) begin                               // [RULE_17]
          st_d.state = SDC_ST_IDLE;
          st_d.cnt   = '0;
        end
      end
      default: st_d.state = SDC_ST_IDLE;
    endcase
  end

  // State register; reset stands in for the power-on clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q       <= '0;
      st_q.sync_s1   <= 2'h3;
      st_q.sync_prev <= 1'b1;
      // Idle-high history, so no false clock edge follows reset
      st_q.sclk_s1   <= 2'h3;
      st_q.sclk_prev <= 1'b1;
      st_q.state <= SDC_ST_IDLE;
      st_q.code  <= CODE_RST;                              // [RULE_10]
      st_q.mode  <= SDC_PM_NORMAL;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // Outputs; code kept through power-down [RULE_11], unsigned binary [RULE_13]
  assign code          = st_q.code;
  assign power_mode    = st_q.mode;
  assign power_mode_hi = st_q.mode[1];
  assign power_mode_lo = st_q.mode[0];
  assign code_update   = st_q.upd;
  // Amplifier off in any power-down mode; 1k or 100k termination chosen, none in SDC_PM_HIZ
  assign out_ctl.amp_on    = (st_q.mode == SDC_PM_NORMAL); // [RULE_12]
  assign out_ctl.term_1k   = (st_q.mode == SDC_PM_1K);
  assign out_ctl.term_100k = (st_q.mode == SDC_PM_100K);

  // Assertions
  // Abort leaves code and mode alone and empties the shifter
  property p_abort_keeps;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && st_q.state == SDC_ST_SHIFT && sync_rise)
        |=> $stable(code) && $stable(power_mode) && shift_zero;
  endproperty
  a_abort_keeps: assert property (p_abort_keeps) else $error("abort changed state"); // [RULE_09]

  // Abort also returns to idle with a fresh counter and no pulse
  property p_abort_idle;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && st_q.state == SDC_ST_SHIFT && sync_rise)
        |=> st_q.state == SDC_ST_IDLE && st_q.cnt == 5'h00 && !code_update;
  endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("abort did not return to idle"); // [RULE_09]

  property p_update_16;
    @(posedge clk) disable iff (sys_rst)
      $rose(code_update) |-> $past(st_q.cnt) == 5'h0f;
  endproperty
  a_update_16: assert property (p_update_16) else $error("update not on 16th edge"); // [RULE_02]

  property p_code_only_on_upd;
    @(posedge clk) disable iff (sys_rst)
      !code_update |-> $stable(code) && $stable(power_mode);
  endproperty
  a_code_only_on_upd: assert property (p_code_only_on_upd) else $error("code moved without frame"); // [RULE_11]

  property p_no_restart_low;
    @(posedge clk) disable iff (sys_rst)
      (st_q.state == SDC_ST_DONE && !sync_rise) |=> st_q.state == SDC_ST_DONE;
  endproperty
  a_no_restart_low: assert property (p_no_restart_low) else $error("frame restarted without sync edge"); // [RULE_03]

  property p_start_clear;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && st_q.state == SDC_ST_IDLE && sync_fall) |=> st_q.cnt == 5'h00 && st_q.state == SDC_ST_SHIFT;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("counter not cleared at start"); // [RULE_17]

  property p_shift_in;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && st_q.state == SDC_ST_SHIFT && !sync_rise && sclk_fall && st_q.cnt < 5'h0f)
        |=> st_q.shift[0] == $past(pins.din);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("bit not shifted"); // [RULE_01]

  // Power-down cuts the amplifier and picks exactly the chosen network
  property p_term;
    @(posedge clk) disable iff (sys_rst)
      (power_mode != SDC_PM_NORMAL)
        |-> !out_ctl.amp_on && (out_ctl.term_1k == (power_mode == SDC_PM_1K))
            && (out_ctl.term_100k == (power_mode == SDC_PM_100K));
  endproperty
  a_term: assert property (p_term) else $error("termination wrong"); // [RULE_12]

  // Normal mode drives through the amplifier with no termination
  property p_normal_out;
    @(posedge clk) disable iff (sys_rst)
      (power_mode == SDC_PM_NORMAL) |-> out_ctl.amp_on && !out_ctl.term_1k && !out_ctl.term_100k;
  endproperty
  a_normal_out: assert property (p_normal_out) else $error("normal mode output wrong"); // [RULE_12]

  property p_mode_bits;
    @(posedge clk) disable iff (sys_rst)
      $rose(code_update) |-> power_mode == $past(st_q.shift[12:11]);
  endproperty
  a_mode_bits: assert property (p_mode_bits) else $error("mode from wrong bits"); // [RULE_07]

  // Execute pulse is a single enabled cycle wide; it holds while clk_en is low
  property p_pulse_one;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && code_update) |=> !code_update;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("execute pulse wider than one cycle"); // [RULE_02]

  // Execute pulse only ever seen once the frame is complete
  property p_upd_done;
    @(posedge clk) disable iff (sys_rst)
      code_update |-> st_q.state == SDC_ST_DONE;
  endproperty
  a_upd_done: assert property (p_upd_done) else $error("execute pulse outside done state"); // [RULE_02]

  // Code takes the eleven stored bits plus the final sampled bit
  property p_code_bits;
    @(posedge clk) disable iff (sys_rst)
      $rose(code_update) |-> code == {$past(st_q.shift[CODE_MSB_POS-1:CODE_LSB_POS]), $past(pins.din)};
  endproperty
  a_code_bits: assert property (p_code_bits) else $error("code from wrong bits"); // [RULE_08]

  // Split mode bits always agree with the mode field
  property p_mode_split;
    @(posedge clk) disable iff (sys_rst)
      {power_mode_hi, power_mode_lo} == power_mode;
  endproperty
  a_mode_split: assert property (p_mode_split) else $error("mode bits disagree"); // [RULE_07]

  // Reset leaves a zero code in normal mode; no disable here on purpose
  property p_reset_zero;
    @(posedge clk)
      sys_rst |=> code == CODE_RST && power_mode == SDC_PM_NORMAL && !code_update;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset did not clear code"); // [RULE_10]

  // Idle waits for a falling sync; a low level alone opens nothing
  property p_idle_wait;
    @(posedge clk) disable iff (sys_rst)
      (st_q.state == SDC_ST_IDLE && !(clk_en && sync_fall)) |=> st_q.state == SDC_ST_IDLE;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("frame opened without sync fall"); // [RULE_03]

  // Clocks after the sixteenth fall neither shift nor execute
  property p_done_ignores;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && st_q.state == SDC_ST_DONE && sclk_fall)
        |=> !code_update && $stable(st_q.shift) && $stable(code);
  endproperty
  a_done_ignores: assert property (p_done_ignores) else $error("extra clock acted"); // [RULE_17]

  // Rising sync releases the done state
  property p_done_exit;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && st_q.state == SDC_ST_DONE && sync_rise) |=> st_q.state == SDC_ST_IDLE;
  endproperty
  a_done_exit: assert property (p_done_exit) else $error("done state not released"); // [RULE_17]

  // Edge counter never passes the last frame bit
  property p_cnt_bound;
    @(posedge clk) disable iff (sys_rst)
      st_q.cnt <= LAST_EDGE;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound) else $error("edge counter overran"); // [RULE_17]

  // Low enable holds every flip-flop, synchronisers included
  property p_freeze;
    @(posedge clk) disable iff (sys_rst)
      !clk_en |=> $stable(st_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

  // State register always holds exactly one legal code
  property p_onehot;
    @(posedge clk) disable iff (sys_rst)
      $onehot(st_q.state);
  endproperty
  a_onehot: assert property (p_onehot) else $error("state code not one-hot");

  // Main scenarios worth seeing
  c_frame:  cover property (@(posedge clk) $rose(code_update));
  c_abort:  cover property (@(posedge clk) st_q.state == SDC_ST_SHIFT && sync_rise);
  c_pd:     cover property (@(posedge clk) power_mode == SDC_PM_HIZ);
  c_extra:  cover property (@(posedge clk) st_q.state == SDC_ST_DONE && sclk_fall);
  c_freeze: cover property (@(posedge clk) !clk_en && st_q.state == SDC_ST_IDLE);

endmodule // sdc_core

`default_nettype wire

// File: verif/sdc_host.sv
// Host model driving the three-wire write link of the converter front end.
// Assumes the bench clock paces it; link clock period 8 clk (320 ns), idle high.
`timescale 1ns/1ps
`default_nettype none
module sdc_host (
  // Bench clock for pacing
  input  wire logic clk,
  // Link pins
  output logic      sync_n,
  output logic      sclk,
  output logic      din
);
  // Idle link at time zero
  initial begin
    sync_n = 1'b1;
    sclk   = 1'b1;
    din    = 1'b0;
  end

  // Wait n falling clock edges
  task automatic pause(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Send nbits+extra clocks of word, MSB first; abort if nbits+extra below 16 and hold_low clear
  task automatic send(input logic [15:0] word, input int nbits, input int extra, input bit hold_low);
    sync_n = 1'b1;                                // High gap before each frame
    pause(3);
    sync_n = 1'b0;
    pause(4);
    for (int i = 0; i < nbits + extra; i++) begin
      din = word[15 - (i % 16)];
      pause(4);
      sclk = 1'b0;                                // Falls 320 ns apart, 640 ns across the byte gap
      pause(4);
      sclk = 1'b1;
      if (i == 7) pause(8);                       // Byte gap, sync stays low
    end
    pause(2);
    din = ~din;                                   // Released data is not held
    if (!hold_low) sync_n = 1'b1;                 // Idle low when asked
  endtask
endmodule // sdc_host
`default_nettype wire

// File: verif/sdc_core_test.sv
// Self-checking bench for the converter input front end.
// Assumes sdc_host paces the link; clk_en held high except while t_freeze drops it for one frame.
`timescale 1ns/1ps
`default_nettype none
module sdc_core_test;
  import sdc_pkg::*;
  logic                 clk = 1'b0;      // System clock
  logic                 sys_rst = 1'b1;  // Reset, held at start
  logic                 clk_en = 1'b1;   // Clock enable, low freezes the block
  logic                 sync_n, sclk, din;
  logic [CODE_BITS-1:0] code;            // Code register
  sdc_mode_t            power_mode;      // Mode register
  logic                 pm_hi, pm_lo;    // Mode bits
  sdc_out_t             out_ctl;         // Termination controls
  logic                 code_update;     // Execute pulse
  int                   miscompares = 0, tests_run = 0, updates = 0;
  logic [11:0]          exp_c = 12'h000; // Expected code
  logic [1:0]           exp_m = 2'h0;    // Expected mode
  int                   exp_n = 0;       // Expected pulse count

  // Clock of 40 ns
  always #20 clk = ~clk;

  sdc_host HOST (.clk(clk), .sync_n(sync_n), .sclk(sclk), .din(din));
  sdc_core DUT (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .sync_n(sync_n), .sclk(sclk), .din(din),
    .code(code), .power_mode(power_mode), .power_mode_hi(pm_hi), .power_mode_lo(pm_lo),
    .out_ctl(out_ctl), .code_update(code_update));

  // Count one-cycle execute pulses
  always @(negedge clk) if (code_update === 1'b1) updates <= updates + 1;

  // Compare and report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic close_out;
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Check all outputs against expectation, after results land
  task automatic settle;
    HOST.pause(8);
    check(16'(code), 16'(exp_c));
    check(16'(power_mode), 16'(exp_m));
    check(16'({pm_hi, pm_lo}), 16'(exp_m));
    check(16'(out_ctl), 16'({exp_m == 2'h0, exp_m == 2'h1, exp_m == 2'h2}));
    check(16'(updates), 16'(exp_n));
  endtask

  // Every mode, boundary codes, ignored top bits set
  task automatic t_modes;
    logic [11:0] codes [4];
    codes = '{12'hfff, 12'h001, 12'h800, 12'h5a3};
    for (int m = 0; m < 4; m++) begin
      exp_m = 2'(m);
      exp_c = codes[m];
      exp_n++;
      HOST.send({2'b11, exp_m, exp_c}, 16, 0, m[0]);
      settle();
    end
  endtask

  // Sync rises after 15 falls: nothing changes
  task automatic t_abort;
    HOST.send({2'b00, 2'b01, 12'h123}, 15, 0, 1'b0);
    settle();
  endtask

  // Extra clocks after the 16th fall with sync held low are ignored
  task automatic t_extra;
    exp_m = 2'h0;
    exp_c = 12'h3c6;
    exp_n++;
    HOST.send({2'b01, exp_m, exp_c}, 16, 16, 1'b1);
    settle();
    exp_m = 2'h2;
    exp_n++;
    HOST.send({2'b10, exp_m, exp_c}, 16, 0, 1'b0);           // Code kept in power-down
    settle();
  endtask

  // Low enable: a whole frame passes unseen, then the block resumes
  task automatic t_freeze;
    @(negedge clk) clk_en = 1'b0;
    HOST.send({2'b00, 2'b01, 12'h0ab}, 16, 0, 1'b0);
    settle();                                                // Frozen, nothing moves
    clk_en = 1'b1;
    exp_m = 2'h1;
    exp_c = 12'h0ab;
    exp_n++;
    HOST.send({2'b00, exp_m, exp_c}, 16, 0, 1'b0);
    settle();
  endtask

  // Reset in mid-run clears code and mode again
  task automatic t_reset;
    @(negedge clk) sys_rst = 1'b1;
    HOST.pause(2);
    sys_rst = 1'b0;
    exp_m = 2'h0;
    exp_c = CODE_RST;
    HOST.pause(3);
    settle();
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    HOST.pause(3);
    check(16'(updates), 16'h0000);
    settle();
    t_modes();
    t_abort();
    t_extra();
    t_freeze();
    t_reset();
    close_out();
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    close_out();
  end
endmodule // sdc_core_test
`default_nettype wire
